//--- resistor_oscillator_measure.v
// The Avalon-MM register port is this design's own decision.
`include "rfc_map.vh"
module resistor_oscillator_measure (
   input  wire        core_clk_i,
   input  wire        rst_b_i,
   input  wire [7:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   output reg  [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   input  wire        osc_cap_i,
   input  wire        counter_pin_i,
   output wire        resistor_pin_ch0_oe_b_o,
   output wire        resistor_pin_ch1_oe_b_o,
   output wire        resistor_pin_ch2_oe_b_o,
   output wire        resistor_pin_out_o,
   output reg         timer0_event_o,
   output reg         slow_clock_event_o,
   output wire        osc_running_o,
   output wire        slow_clock_type_o,
   output wire        fast_clock_select_o,
   output wire [7:0]  port1_upper_pin_function_o
);
   reg  [7:0] pin_func_q;
   reg  [4:0] conv_ctrl_q;
   reg  [7:0] clk_ctrl_q;
   reg  [3:0] aux_ctrl_q;
   reg        ack_q;
   reg        cap_d1_q;
   wire       cap_sync;
   wire       cap_rise;
   wire       pin_sync;
   reg        pin_d1_q;
   wire       pin_rise;
   wire       tick;
   wire       req;
   wire [1:0] ch;
   wire       cap_pin_en;
   wire       ch_pin_en;
   // Pin code 11 hands the pin to the converter
   function pin_is_conv;
      input [1:0] code;
      begin
         pin_is_conv = (code == `PIN_CONV_CODE);
      end
   endfunction
   // Request served one cycle after it is raised
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_q;
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end
   wire wr = avs_write_i & ack_q;
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_func_q  <= `RST_PIN_FUNC;
         conv_ctrl_q <= `RST_CONV_CTRL;
         clk_ctrl_q  <= `RST_CLK_CTRL;
         aux_ctrl_q  <= `RST_AUX_CTRL;
      end else if (wr) begin
         case (avs_address_i)
            `ADDR_PIN_FUNC: begin
               pin_func_q <= avs_writedata_i[7:0];
            end
            `ADDR_CONV_CTRL: begin
               conv_ctrl_q <= avs_writedata_i[4:0];
            end
            `ADDR_CLK_CTRL: begin
               clk_ctrl_q[6:0] <= avs_writedata_i[6:0];
               if (clk_ctrl_q[`CLK_FAST_BIT]) begin
                  clk_ctrl_q[7] <= avs_writedata_i[7]; // R6
               end
            end
            `ADDR_AUX_CTRL: begin
               aux_ctrl_q <= avs_writedata_i[3:0];
            end
            default: begin
            end
         endcase
      end
   end
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (avs_read_i & ~ack_q) begin
         case (avs_address_i)
            `ADDR_PIN_FUNC:  avs_readdata_o <= {24'h000000, pin_func_q};
            `ADDR_CONV_CTRL: avs_readdata_o <= {27'h0, conv_ctrl_q};
            `ADDR_CLK_CTRL:  avs_readdata_o <= {24'h000000, clk_ctrl_q};
            `ADDR_AUX_CTRL:  avs_readdata_o <= {28'h0000000, aux_ctrl_q};
            default:         avs_readdata_o <= 32'h00000000;
         endcase
      end
   end
   assign ch = conv_ctrl_q[1:0];
   // R8
   assign cap_pin_en = pin_is_conv(pin_func_q[7:6]);
   // R5 R12
   assign osc_running_o = cap_pin_en & ~aux_ctrl_q[`AUX_STOP_BIT] & (ch != `CH_NONE);
   // R9 R2
   assign ch_pin_en = (ch == 2'h0) ? pin_is_conv(pin_func_q[1:0]) :
                      (ch == 2'h1) ? pin_is_conv(pin_func_q[3:2]) :
                      (ch == 2'h2) ? pin_is_conv(pin_func_q[5:4]) : 1'b0;
   // R1: only the selected resistor pin is ever driven
   assign resistor_pin_ch0_oe_b_o = ~(osc_running_o & ch_pin_en & (ch == 2'h0));
   assign resistor_pin_ch1_oe_b_o = ~(osc_running_o & ch_pin_en & (ch == 2'h1));
   assign resistor_pin_ch2_oe_b_o = ~(osc_running_o & ch_pin_en & (ch == 2'h2));
   // Feedback inverts capacitor level to keep the RC swinging
   assign resistor_pin_out_o = ~cap_sync;
   conv_sync u_cap_sync (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .async_i    (osc_cap_i),
      .sync_o     (cap_sync)
   );
   conv_sync u_pin_sync (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .async_i    (counter_pin_i),
      .sync_o     (pin_sync)
   );
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cap_d1_q <= 1'b0;
         pin_d1_q <= 1'b0;
         timer0_event_o <= 1'b0;
         slow_clock_event_o <= 1'b0;
      end else begin
         cap_d1_q <= cap_sync;
         pin_d1_q <= pin_sync;
         // R3 R10
         timer0_event_o <= conv_ctrl_q[`CONV_T0SEL_BIT] ? tick : pin_rise;
         slow_clock_event_o <= cap_rise; // R10
      end
   end
   assign cap_rise = cap_sync & ~cap_d1_q & osc_running_o;
   assign pin_rise = pin_sync & ~pin_d1_q;
   conv_prescaler u_psc (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .edge_i     (cap_rise),
      .code_i     (conv_ctrl_q[3:2]),
      .tick_o     (tick)
   );
   // R11: the crystal reference timer lives outside this block
   assign slow_clock_type_o = clk_ctrl_q[`CLK_STYPE_BIT];
   assign fast_clock_select_o = clk_ctrl_q[`CLK_FAST_BIT];
   assign port1_upper_pin_function_o = pin_func_q;
endmodule

//--- rfc_map.vh
`ifndef CONV_MAP_VH
`define CONV_MAP_VH
// Summary of operation
// R1 - Only one resistor oscillator runs at a time and the selected one alone clocks the converter.
// R2 - The oscillator is the capacitor pin plus the resistor pin named by the channel field.
// R3 - Timer-input select 1 feeds the prescaled converter clock to Timer0, 0 feeds the counter pin.
// R4 - The prescaler divides by 64, 16, 4 or 1 for codes 00, 01, 10, 11.
// R5 - The stop bit at 1 halts the oscillation; it runs only while the bit is 0.
// R6 - The slow-clock-type bit changes only while the fast clock is selected.
// R7 - Software sets up the oscillator before choosing it as slow clock.
// R8 - Pin code 11 on P1.7 makes it the capacitor pin; other codes are port modes.
// R9 - Pin code 11 on P1.6, P1.5, P1.4 makes them resistor pins of channels 2, 1, 0.
// R10 - The converter clock can be counted by Timer0 or used as system slow clock.
// R11 - The crystal-clocked reference timer gives the interval for comparison.
// R12 - Channel code 11 enables no resistor channel.
`define ADDR_PIN_FUNC   8'ha3
`define ADDR_CONV_CTRL  8'haf
`define ADDR_CLK_CTRL   8'hd8
`define ADDR_AUX_CTRL   8'hf8
`define RST_PIN_FUNC    8'h00
`define RST_CONV_CTRL   5'h0c
`define RST_CLK_CTRL    8'h67
`define RST_AUX_CTRL    4'h0
`define CONV_T0SEL_BIT  4
`define CLK_STYPE_BIT   7
`define CLK_FAST_BIT    2
`define AUX_STOP_BIT    1
`define PIN_CONV_CODE   2'h3
`define CH_NONE         2'h3
`endif

//--- conv_sync.v
module conv_sync (
   input  wire core_clk_i,
   input  wire rst_b_i,
   input  wire async_i,
   output wire sync_o
);
   reg meta_q;
   reg sync_q;
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end
   assign sync_o = sync_q;
endmodule

//--- conv_prescaler.v
`include "rfc_map.vh"
module conv_prescaler (
   input  wire       core_clk_i,
   input  wire       rst_b_i,
   input  wire       edge_i,
   input  wire [1:0] code_i,
   output wire       tick_o
);
   reg  [5:0] cnt_q;
   wire [5:0] last;
   // R4
   assign last = (code_i == 2'h0) ? 6'h3f : (code_i == 2'h1) ? 6'h0f :
                 (code_i == 2'h2) ? 6'h03 : 6'h00;
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= 6'h00;
      end else if (edge_i) begin
         cnt_q <= (cnt_q >= last) ? 6'h00 : cnt_q + 6'h01;
      end
   end
   assign tick_o = edge_i && (cnt_q >= last);
endmodule

//--- resistor_oscillator_measure_checker.sv
module osc_measure_checker (
   input wire        core_clk_i,
   input wire        rst_b_i,
   input wire [7:0]  avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire        avs_waitrequest_o,
   input wire        resistor_pin_ch0_oe_b_o,
   input wire        resistor_pin_ch1_oe_b_o,
   input wire        resistor_pin_ch2_oe_b_o,
   input wire        slow_clock_event_o,
   input wire        timer0_event_o,
   input wire        osc_running_o,
   input wire        slow_clock_type_o,
   input wire        fast_clock_select_o,
   input wire [7:0]  port1_upper_pin_function_o
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [2:0] drv = ~{resistor_pin_ch2_oe_b_o, resistor_pin_ch1_oe_b_o, resistor_pin_ch0_oe_b_o};
   wire [7:0] pf = port1_upper_pin_function_o;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_one_channel: assert property ($onehot0(drv)) else $error("two pins driven");
   a_pin_code: assert property ((drv & ~{&pf[5:4], &pf[3:2], &pf[1:0]}) == 3'h0)
      else $error("pin driven without code 11");
   a_cap_pin: assert property (osc_running_o |-> &pf[7:6]) else $error("cap pin off");
   a_idle_pins: assert property (!osc_running_o |-> drv == 3'h0) else $error("idle drive");
   a_type_frozen: assert property (!fast_clock_select_o |=> $stable(slow_clock_type_o))
      else $error("type changed in slow mode");
   a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o) else $error("wait too long");
   a_fast_write: assert property (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'hd8
      |=> fast_clock_select_o == $past(avs_writedata_i[2])) else $error("fast bit");
   a_quiet_stop: assert property (!osc_running_o [*8] |-> !slow_clock_event_o)
      else $error("event while stopped");
   cover property (timer0_event_o);
   cover property (slow_clock_event_o);
   cover property (slow_clock_type_o);
endmodule

//--- rc_sensor_model.sv
module rc_sensor_model (
   input  wire       core_clk_i,
   input  wire [3:0] half_i,
   input  wire [2:0] oe_b_i,
   output logic      cap_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   initial cap_o = 1'h0;
   // Network rings only while one resistor pin is driven
   always @(posedge core_clk_i) begin
      n <= (&oe_b_i || n >= half_i - 1) ? 0 : n + 1;
      if (!(&oe_b_i) && n >= half_i - 1) cap_o <= ~cap_o;
   end
endmodule

//--- tb_resistor_oscillator_measure.sv
module tb_resistor_oscillator_measure;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 1'h0, rst_b_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0;
   logic counter_pin_i = 1'h0;
   logic [7:0] avs_address_i = 8'h00;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] half = 4'h2;
   wire [31:0] avs_readdata_o;
   wire [7:0] port1_upper_pin_function_o;
   wire osc_cap_i, avs_waitrequest_o, resistor_pin_out_o, timer0_event_o, slow_clock_event_o;
   wire resistor_pin_ch0_oe_b_o, resistor_pin_ch1_oe_b_o, resistor_pin_ch2_oe_b_o;
   wire osc_running_o, slow_clock_type_o, fast_clock_select_o;
   wire [2:0] oe = {resistor_pin_ch2_oe_b_o, resistor_pin_ch1_oe_b_o, resistor_pin_ch0_oe_b_o};
   int miscompares = 0, compares = 0, cyc = 0, t0n = 0, sn = 0, q = 0;
   logic [31:0] exp_q[$];
   resistor_oscillator_measure u_resistor_oscillator_measure (.*);
   rc_sensor_model u_rc_sensor_model (.core_clk_i, .half_i(half), .oe_b_i(oe), .cap_o(osc_cap_i));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= {24'($urandom()), d};
      @(posedge core_clk_i iff !avs_waitrequest_o);
      avs_write_i <= 1'h0;
      avs_read_i <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'h0, a, 8'h00);
   endtask
   initial forever #20 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc++;
      t0n += timer0_event_o;
      sn += slow_clock_event_o;
      if (avs_read_i && !avs_waitrequest_o) check(avs_readdata_o, exp_q.pop_front());
      if (cyc == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(44168));
      repeat (8) @(posedge core_clk_i);
      rst_b_i <= 1'h1;
      rd(8'ha3, 32'h00);
      rd(8'haf, 32'h0c);
      rd(8'hd8, 32'h67);
      rd(8'hf8, 32'h00);
      rd(8'h10, 32'h00);
      bus(1'h1, 8'hd8, 8'h63);
      bus(1'h1, 8'hd8, 8'he3);
      rd(8'hd8, 32'h63);
      bus(1'h1, 8'hd8, 8'he7);
      rd(8'hd8, 32'h67);
      bus(1'h1, 8'ha3, 8'hff);
      bus(1'h1, 8'haf, 8'h10);
      bus(1'h1, 8'hd8, 8'he7);
      rd(8'hd8, 32'he7);
      check(slow_clock_type_o, 32'h1);
      $display("clock type test done");
      bus(1'h1, 8'ha3, 8'hff);
      for (int c = 0; c < 4; c++) begin
         half <= 4'($urandom_range(9, 2));
         bus(1'h1, 8'haf, 8'(8'h10 | c));
         repeat (4) @(posedge core_clk_i);
         check({osc_running_o, oe}, c == 3 ? 4'h7 : {1'h1, 3'(~(3'h1 << c))});
      end
      bus(1'h1, 8'haf, 8'h10);
      bus(1'h1, 8'ha3, 8'hfc);
      repeat (2) @(posedge core_clk_i);
      check({osc_running_o, oe}, 32'hf);
      bus(1'h1, 8'ha3, 8'h3f);
      repeat (2) @(posedge core_clk_i);
      check({osc_running_o, oe}, 32'h7);
      bus(1'h1, 8'ha3, 8'hff);
      repeat (2) @(posedge core_clk_i);
      check(port1_upper_pin_function_o, 32'hff);
      $display("channel test done");
      half <= 4'h2;
      for (int p = 0; p < 4; p++) begin
         bus(1'h1, 8'haf, 8'(8'h11 | p << 2));
         repeat (2) @(posedge core_clk_i);
         t0n = 0;
         sn = 0;
         repeat (2000) @(posedge core_clk_i);
         q = sn >> (6 - 2 * p);
         check(32'(t0n + 1 >= q && t0n <= q + 1), 32'h1);
      end
      bus(1'h1, 8'haf, 8'h01);
      repeat (2) @(posedge core_clk_i);
      t0n = 0;
      repeat (5) begin
         counter_pin_i <= 1'h1;
         repeat (4) @(posedge core_clk_i);
         counter_pin_i <= 1'h0;
         repeat (4) @(posedge core_clk_i);
      end
      check(t0n, 32'h5);
      $display("timer input test done");
      bus(1'h1, 8'hf8, 8'h02);
      repeat (8) @(posedge core_clk_i);
      sn = 0;
      repeat (100) @(posedge core_clk_i);
      check({osc_running_o, oe, 4'(sn)}, 8'h70);
      check(resistor_pin_out_o, 32'(!osc_cap_i));
      rd(8'hf8, 32'h02);
      $display("stop test done");
      complete_run();
   end
endmodule
bind resistor_oscillator_measure osc_measure_checker u_osc_measure_checker (.*);
